/* File: design/mwd_assem.sv */
// packs decoded bits into bytes, first bit in the low position
`timescale 1ns/100ps
module mwd_assem #(
  parameter int NBITS = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // carrier
  mwd_bit_if.asm   bif
);
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic       stb_r;
  logic [7:0] data_r;
  wire  [7:0] sh_nxt = {bif.bit_val, sh_r[7:1]};
  wire        full_w = bif.bit_valid && (cnt_r == 3'(NBITS - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r  <= 3'h0;
      sh_r   <= 8'h00;
      stb_r  <= 1'b0;
      data_r <= 8'h00;
    end else begin
      cnt_r  <= !bif.en ? 3'h0 : bif.bit_valid ? cnt_r + 3'h1 : cnt_r;
      sh_r   <= bif.bit_valid ? sh_nxt : sh_r;
      stb_r  <= bif.en && full_w;
      data_r <= full_w ? sh_nxt : data_r;
    end
  end

  assign bif.byte_stb  = stb_r;
  assign bif.byte_data = data_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_lsb_first: assert property (bif.en && full_w |=> stb_r &&
    data_r[7] == $past(bif.bit_val)) else $error("byte order wrong");
endmodule // mwd_assem

/* File: design/mwd_clkrec.sv */
// bit clock recovery and manchester to nrz decoding
`timescale 1ns/100ps
`include "mwd_params.svh"
module mwd_clkrec #(
  parameter int BIT_CYC = `MWD_BIT_CYC,
  parameter int PH_W    = `MWD_PH_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sliced discriminator output
  input wire logic line_in,
  // carrier
  mwd_bit_if.rec   bif
);
  localparam logic [PH_W-1:0] HALF = PH_W'(BIT_CYC / 2);
  localparam logic [PH_W-1:0] QTR  = PH_W'(BIT_CYC / 4);
  localparam logic [PH_W-1:0] LAST = PH_W'(BIT_CYC - 1);
  localparam logic [PH_W-1:0] BNDH = PH_W'(BIT_CYC - BIT_CYC / 4);

  logic                    line_r;
  logic                    line_d_r;
  logic [PH_W-1:0]         ph_r;
  logic [PH_W-1:0]         ph_nxt;
  logic                    first_r;
  logic                    got_r;
  logic                    seen_r;
  logic                    bit_v_r;
  logic                    bit_r;
  mwd_pkg::mwd_sync_type   mode_r;
  mwd_pkg::mwd_sync_type   mode_nxt;
  wire                     edge_w = line_r ^ line_d_r;
  wire                     mid_w  = (ph_r >= QTR) && (ph_r < BNDH);
  wire                     end_w  = (ph_r == LAST);
  wire signed [PH_W:0]     err_w  = $signed({1'b0, ph_r}) -
                                    $signed({1'b0, HALF});
  wire signed [PH_W:0]     corr_w = err_w >>> mwd_pkg::mwd_bw_shift(bif.bw);
  wire signed [PH_W:0]     adj_w  = $signed({1'b0, ph_r}) - corr_w +
                                    $signed({{PH_W{1'b0}}, 1'b1});
  wire [PH_W-1:0]          wrap_w = end_w ? '0 : ph_r + 1'b1;
  // fast mode jumps on any mid edge, or on any edge once sync is lost
  wire acc_fast_w = edge_w && (mid_w || !seen_r);
  // lock mode trusts only edges where the loop expects the mid point
  wire acc_lock_w = edge_w && mid_w;
  wire acc_w = (mode_r == mwd_pkg::SYNC_FAST) ? acc_fast_w :
               (mode_r == mwd_pkg::SYNC_LOCK) ? acc_lock_w : 1'b0;

  assign mode_nxt = !bif.en ? mwd_pkg::SYNC_OFF :
                    bif.lock_sel ? mwd_pkg::SYNC_LOCK : mwd_pkg::SYNC_FAST;

  always_comb begin
    case (mode_r)
      mwd_pkg::SYNC_OFF:  ph_nxt = '0;
      mwd_pkg::SYNC_FAST: ph_nxt = acc_fast_w ? HALF + 1'b1 : wrap_w;
      mwd_pkg::SYNC_LOCK: ph_nxt = acc_lock_w ? adj_w[PH_W-1:0] : wrap_w;
      default:            ph_nxt = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_r   <= 1'b0;
      line_d_r <= 1'b0;
      ph_r     <= '0;
      mode_r   <= mwd_pkg::SYNC_OFF;
      first_r  <= 1'b0;
      got_r    <= 1'b0;
      seen_r   <= 1'b0;
      bit_v_r  <= 1'b0;
      bit_r    <= 1'b0;
    end else begin
      line_r   <= line_in;
      line_d_r <= line_r;
      ph_r     <= ph_nxt;
      mode_r   <= mode_nxt;
      first_r  <= (ph_r == QTR) ? line_r : first_r;
      got_r    <= end_w ? 1'b0 : (got_r | acc_w);
      seen_r   <= (mode_r == mwd_pkg::SYNC_OFF) ? 1'b0 :
                  end_w ? (got_r | acc_w) : seen_r;
      bit_v_r  <= (mode_r != mwd_pkg::SYNC_OFF) && end_w;
      // high first half is a 0, low first half a 1: line xor clock
      bit_r    <= end_w ? ~first_r : bit_r;
    end
  end

  assign bif.bit_valid = bit_v_r;
  assign bif.bit_val   = bit_r;
  assign bif.synced    = seen_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_fast_jump: assert property ((mode_r == mwd_pkg::SYNC_FAST) && edge_w &&
    mid_w |=> ph_r == HALF + 1'b1) else $error("fast sync missed");
  a_bit_spacing: assert property (bit_v_r |=> !bit_v_r [*8])
    else $error("bit strobes too close");
  a_nrz_value: assert property ((ph_r == QTR) && line_r && end_w == 1'b0
    ##1 (!end_w && ph_r != QTR) [*1] |-> ##0 first_r)
    else $error("first half not captured");
endmodule // mwd_clkrec

/* File: design/mwd_receiver.sv */
// manchester wide-band data receiver with dsp and mcu apb ports
`timescale 1ns/100ps
`include "mwd_params.svh"
module mwd_receiver #(
  parameter int BIT_CYC = `MWD_BIT_CYC
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // sliced manchester line
  input  wire logic        LINE_IN,
  // dsp apb slave
  input  wire logic        D_PSEL,
  input  wire logic        D_PENABLE,
  input  wire logic        D_PWRITE,
  input  wire logic [7:0]  D_PADDR,
  input  wire logic [31:0] D_PWDATA,
  output logic      [31:0] D_PRDATA,
  output logic             D_PREADY,
  output logic             D_PSLVERR,
  // mcu apb slave
  input  wire logic        M_PSEL,
  input  wire logic        M_PENABLE,
  input  wire logic        M_PWRITE,
  input  wire logic [7:0]  M_PADDR,
  input  wire logic [31:0] M_PWDATA,
  output logic      [31:0] M_PRDATA,
  output logic             M_PREADY,
  output logic             M_PSLVERR,
  // data interrupts, active high levels
  output logic             DSP_IRQ,
  output logic             MCU_IRQ
);
  function automatic mwd_pkg::mwd_sel_type dec(input logic [7:0] a);
    case (a)
      `MWD_OFF_DATA: return mwd_pkg::SEL_DATA;
      `MWD_OFF_CTRL: return mwd_pkg::SEL_CTRL;
      `MWD_OFF_STAT: return mwd_pkg::SEL_STAT;
      default:       return mwd_pkg::SEL_NONE;
    endcase
  endfunction

  mwd_bit_if bif ();

  // index 0 is the dsp port, index 1 the mcu port
  logic [1:0]            psel;
  logic [1:0]            pen;
  logic [1:0]            pwr;
  logic [7:0]            paddr   [2];
  logic [31:0]           pwdata  [2];
  logic [31:0]           prdata_r[2];
  logic [31:0]           rd_nxt  [2];
  mwd_pkg::mwd_sel_type  sel     [2];
  logic [1:0]            setup;
  logic [1:0]            acc;
  logic [1:0]            rd_data;
  logic [1:0]            wr_ctrl;
  logic [1:0]            wr_clr;
  logic [1:0]            irq_r;
  logic [1:0]            irq_nxt;
  logic [1:0]            late_r;
  logic [4:0]            ctrl_r;
  logic [4:0]            ctrl_nxt;
  logic [7:0]            data_r;

  assign psel      = {M_PSEL, D_PSEL};
  assign pen       = {M_PENABLE, D_PENABLE};
  assign pwr       = {M_PWRITE, D_PWRITE};
  assign paddr[0]  = D_PADDR;
  assign paddr[1]  = M_PADDR;
  assign pwdata[0] = D_PWDATA;
  assign pwdata[1] = M_PWDATA;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign sel[p]     = dec(paddr[p]);
    assign setup[p]   = psel[p] && !pen[p];
    assign acc[p]     = psel[p] && pen[p];
    assign rd_data[p] = acc[p] && !pwr[p] &&
                        (sel[p] == mwd_pkg::SEL_DATA);
    assign wr_ctrl[p] = acc[p] && pwr[p] && (sel[p] == mwd_pkg::SEL_CTRL);
    assign wr_clr[p]  = acc[p] && pwr[p] && (sel[p] == mwd_pkg::SEL_STAT) &&
                        pwdata[p][`MWD_CLR_BIT];
    // a byte that lands after the setup capture keeps its interrupt,
    // since the reader got the older byte
    assign irq_nxt[p] = bif.byte_stb ||
                        (irq_r[p] && !(rd_data[p] && !late_r[p])
                         && !wr_clr[p]);
    always_comb begin
      case (sel[p])
        mwd_pkg::SEL_DATA: rd_nxt[p] = {24'h000000, data_r};
        mwd_pkg::SEL_CTRL: rd_nxt[p] = {27'h0000000, ctrl_r};
        mwd_pkg::SEL_STAT: rd_nxt[p] = {30'h00000000, bif.synced, irq_r[p]};
        default:           rd_nxt[p] = 32'h00000000;
      endcase
    end
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        prdata_r[p] <= 32'h00000000;
        irq_r[p]    <= 1'b0;
        late_r[p]   <= 1'b0;
      end else begin
        prdata_r[p] <= setup[p] ? rd_nxt[p] : prdata_r[p];
        irq_r[p]    <= irq_nxt[p];
        late_r[p]   <= bif.byte_stb || (late_r[p] && !setup[p]);
      end
    end
  end

  // simultaneous writes: the dsp port takes precedence
  assign ctrl_nxt = wr_ctrl[0] ? pwdata[0][4:0] :
                    wr_ctrl[1] ? pwdata[1][4:0] : ctrl_r;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_r <= `MWD_CTRL_RST;
      data_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      data_r <= bif.byte_stb ? bif.byte_data : data_r;
    end
  end

  // only the enable bit gates the decoder; no receive path is consulted
  assign bif.en       = ctrl_r[`MWD_CTRL_EN];
  assign bif.lock_sel = ctrl_r[`MWD_CTRL_LOCK];
  assign bif.bw       = ctrl_r[`MWD_CTRL_BW_HI:`MWD_CTRL_BW_LO];

  mwd_clkrec #(
    .BIT_CYC (BIT_CYC),
    .PH_W    (`MWD_PH_W)
  ) u_clkrec (
    .clock   (CLOCK),
    .rst     (RST),
    .line_in (LINE_IN),
    .bif     (bif)
  );

  mwd_assem #(
    .NBITS (`MWD_BYTE_BITS)
  ) u_assem (
    .clock (CLOCK),
    .rst   (RST),
    .bif   (bif)
  );

  // zero wait states: read data is captured in the setup cycle
  assign D_PRDATA  = prdata_r[0];
  assign M_PRDATA  = prdata_r[1];
  assign D_PREADY  = 1'b1;
  assign M_PREADY  = 1'b1;
  assign D_PSLVERR = acc[0] && (sel[0] == mwd_pkg::SEL_NONE);
  assign M_PSLVERR = acc[1] && (sel[1] == mwd_pkg::SEL_NONE);
  assign DSP_IRQ   = irq_r[0];
  assign MCU_IRQ   = irq_r[1];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_load;
    bif.byte_stb;
  endsequence
  sequence s_both_up;
    irq_r[0] && irq_r[1];
  endsequence

  a_irq_both: assert property (s_load |=> s_both_up)
    else $error("interrupts not raised together");
  a_data_load: assert property (s_load |=> data_r == $past(bif.byte_data))
    else $error("data register not loaded");
  a_dsp_rdclr: assert property (rd_data[0] && !late_r[0] && !bif.byte_stb
    |=> !irq_r[0] && irq_r[1] == $past(irq_r[1]))
    else $error("dsp read clear wrong");
  a_mcu_wrclr: assert property (wr_clr[1] && !bif.byte_stb
    |=> !MCU_IRQ && DSP_IRQ == $past(DSP_IRQ))
    else $error("mcu clear bit failed");
  a_ctrl_mcu: assert property (wr_ctrl[1] && !wr_ctrl[0]
    |=> ctrl_r == $past(pwdata[1][4:0]))
    else $error("mcu control write lost");
  a_shared_rd: assert property (setup[0] && setup[1] &&
    sel[0] == mwd_pkg::SEL_DATA && sel[1] == mwd_pkg::SEL_DATA
    |=> D_PRDATA == M_PRDATA) else $error("ports read differ");
  a_off_quiet: assert property (!bif.en [*3] |-> !bif.byte_stb)
    else $error("byte while disabled");
  a_set_wins: assert property (bif.byte_stb && rd_data[1] |=> MCU_IRQ)
    else $error("set lost to clear");
  a_byte_gap: assert property (s_load |=> !bif.byte_stb [*8])
    else $error("bytes too close");

  sequence s_dsp_clear;
    wr_clr[0] && !bif.byte_stb;
  endsequence
  sequence s_mcu_read;
    rd_data[1] && !late_r[1] && !bif.byte_stb;
  endsequence

  a_dsp_wrclr: assert property (s_dsp_clear |=> !DSP_IRQ)
    else $error("dsp clear bit failed");
  a_mcu_rdclr: assert property (s_mcu_read |=> !MCU_IRQ)
    else $error("mcu read clear wrong");
  a_irq_hold: assert property (DSP_IRQ && !rd_data[0] && !wr_clr[0]
    |=> DSP_IRQ) else $error("dsp interrupt dropped");
  a_ctrl_dsp: assert property (wr_ctrl[0]
    |=> ctrl_r == $past(pwdata[0][4:0]))
    else $error("dsp control write lost");
  a_rd_snap: assert property (setup[0] && sel[0] == mwd_pkg::SEL_DATA
    |=> D_PRDATA == {24'h000000, $past(data_r)})
    else $error("dsp read data wrong");
endmodule // mwd_receiver

/* File: shared/mwd_bit_if.sv */
// carrier between clock recovery, byte assembly and the register block
`timescale 1ns/100ps
interface mwd_bit_if;
  logic       en;
  logic       lock_sel;
  logic [2:0] bw;
  logic       bit_valid;
  logic       bit_val;
  logic       synced;
  logic       byte_stb;
  logic [7:0] byte_data;
  modport rec (input en, lock_sel, bw, output bit_valid, bit_val, synced);
  modport asm (input en, bit_valid, bit_val, output byte_stb, byte_data);
endinterface

/* File: shared/mwd_params.svh */
// constants for the manchester wide-band data receiver
`ifndef MWD_PARAMS_SVH
`define MWD_PARAMS_SVH
`define MWD_CLK_MHZ    10
`define MWD_BIT_US     100
`define MWD_BIT_CYC    (`MWD_BIT_US * `MWD_CLK_MHZ)
`define MWD_BYTE_BITS  8
`define MWD_BYTE_US    800
`define MWD_PH_W       10
`define MWD_ADDR_W     8
`define MWD_OFF_DATA   8'h00
`define MWD_OFF_CTRL   8'h04
`define MWD_OFF_STAT   8'h08
`define MWD_CTRL_EN    0
`define MWD_CTRL_LOCK  1
`define MWD_CTRL_BW_LO 2
`define MWD_CTRL_BW_HI 4
`define MWD_CTRL_RST   5'h00
`define MWD_STAT_IRQ   0
`define MWD_STAT_SYNC  1
`define MWD_CLR_BIT    0
`define MWD_BW_MAX     3'h6
`endif

/* File: shared/mwd_pkg.sv */
// types and helpers for the manchester wide-band data receiver
package mwd_pkg;
  typedef enum logic [1:0] {
    SYNC_OFF  = 2'b00,
    SYNC_FAST = 2'b01,
    SYNC_LOCK = 2'b10
  } mwd_sync_type;

  typedef enum logic [1:0] {
    SEL_DATA = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_STAT = 2'b10,
    SEL_NONE = 2'b11
  } mwd_sel_type;

  // wider loop bandwidth means a smaller shift of the phase error
  function automatic logic [2:0] mwd_bw_shift(input logic [2:0] bw);
    logic [2:0] b;
    b = (bw > 3'h6) ? 3'h6 : bw;
    return 3'h6 - b;
  endfunction
endpackage

/* File: tb/mwd_line_model.sv */
// manchester line source standing in for the fm discriminator
`timescale 1ns/100ps
module mwd_line_model #(
  parameter int BIT_CYC = 40
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // byte sent over and over, lsb first
  input  wire logic [7:0] pattern,
  // sliced line, always driven
  output logic            line
);
  int         cnt;
  logic [7:0] cur;
  int         idx;
  logic       half;
  assign idx  = cnt / BIT_CYC;
  assign half = (cnt % BIT_CYC) >= (BIT_CYC / 2);
  // pattern is latched at byte start so a change never splits a byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt  <= 0;
      cur  <= 8'h00;
      line <= 1'b0;
    end else begin
      cnt  <= (cnt == 8 * BIT_CYC - 1) ? 0 : cnt + 1;
      if (cnt == 8 * BIT_CYC - 1)
        cur <= pattern;
      // mid-bit edge in every bit; 0 is high then low
      // 1 is low then high, line is clock xor nrz data
      line <= half ? cur[idx] : ~cur[idx];
    end
  end
endmodule // mwd_line_model

/* File: tb/tb.sv */
// self-checking bench for the manchester wide-band data receiver
`timescale 1ns/100ps
module tb;
  localparam int BC = 40;
  typedef struct {
    int         p;
    logic [7:0] pat;
    logic [4:0] ctrl;
  } mwd_row_type;
  // patterns mix equal and unequal neighbours: a uniform stream gives a
  // square wave whose mid and boundary edges cannot be told apart
  mwd_row_type rows[3] = '{'{0, 8'h35, 5'h19}, '{1, 8'hca, 5'h0f},
                           '{0, 8'h0b, 5'h03}};
  logic        clock      = 1'b0;
  logic        rst        = 1'b1;
  logic        line;
  logic [7:0]  pattern    = 8'h00;
  logic        psel[2]    = '{1'b0, 1'b0};
  logic        penable[2] = '{1'b0, 1'b0};
  logic        pwrite[2]  = '{1'b0, 1'b0};
  logic [7:0]  paddr[2]   = '{8'h00, 8'h00};
  logic [31:0] pwdata[2]  = '{32'h0, 32'h0};
  logic [31:0] prdata[2];
  logic        pready[2];
  logic        pslverr[2];
  logic        dsp_irq;
  logic        mcu_irq;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] d;
  logic        hit;
  int          cyc = 0;
  int          t_irq;
  int          t0;
  int          errors = 0;
  int          samples_checked = 0;

  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  mwd_line_model #(.BIT_CYC(BC)) i_mwd_line_model (
    .clock(clock), .rst(rst), .pattern(pattern), .line(line));
  mwd_receiver #(.BIT_CYC(BC)) i_mwd_receiver (
    .CLOCK(clock), .RST(rst), .LINE_IN(line),
    .D_PSEL(psel[0]), .D_PENABLE(penable[0]), .D_PWRITE(pwrite[0]),
    .D_PADDR(paddr[0]), .D_PWDATA(pwdata[0]), .D_PRDATA(prdata[0]),
    .D_PREADY(pready[0]), .D_PSLVERR(pslverr[0]),
    .M_PSEL(psel[1]), .M_PENABLE(penable[1]), .M_PWRITE(pwrite[1]),
    .M_PADDR(paddr[1]), .M_PWDATA(pwdata[1]), .M_PRDATA(prdata[1]),
    .M_PREADY(pready[1]), .M_PSLVERR(pslverr[1]),
    .DSP_IRQ(dsp_irq), .MCU_IRQ(mcu_irq));

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; two idle cycles always separate two transfers
  task automatic apb(int p, logic w, logic [7:0] a, logic [31:0] wd);
    int n;
    @(posedge clock);
    psel[p]    <= 1'b1;
    pwrite[p]  <= w;
    paddr[p]   <= a;
    pwdata[p]  <= wd;
    @(posedge clock);
    penable[p] <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (pready[p] === 1'b1) break;
    end
    rdat = prdata[p];
    rerr = pslverr[p];
    psel[p]    <= 1'b0;
    penable[p] <= 1'b0;
    if (n == 50) begin
      errors++;
      final_report();
    end
    // let the access edge's updates settle before outputs are looked at
    @(posedge clock);
  endtask

  task automatic wait_irq;
    int n;
    for (n = 0; n < 32 * BC; n++) begin
      @(posedge clock);
      #1;
      if (dsp_irq === 1'b1) break;
    end
    if (n == 32 * BC) begin
      errors++;
      final_report();
    end
    t_irq = cyc;
  endtask

  task automatic clr2;
    apb(0, 1'b1, 8'h08, 32'h1);
    apb(1, 1'b1, 8'h08, 32'h1);
  endtask

  // a rotation check, since byte framing starts at an unknown bit
  function automatic logic is_rot(logic [7:0] pat, logic [7:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++)
      if (8'((pat << i) | (pat >> (8 - i))) == v) r = 1'b1;
    return r;
  endfunction

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    apb(0, 1'b0, 8'h00, 32'h0);
    chk("reset data", 32'h0, rdat);
    apb(1, 1'b0, 8'h04, 32'h0);
    chk("reset ctrl", 32'h0, rdat);
    chk("reset irqs", 32'h0, {dsp_irq, mcu_irq});
    $display("reset test done");
    foreach (rows[k]) begin
      pattern <= rows[k].pat;
      apb(rows[k].p, 1'b1, 8'h04, 32'h19);
      wait_irq();
      clr2();
      apb(rows[k].p, 1'b1, 8'h04, {27'h0, rows[k].ctrl});
      apb(1 - rows[k].p, 1'b0, 8'h04, 32'h0);
      chk("ctrl value", {27'h0, rows[k].ctrl}, rdat);
      wait_irq();
      clr2();
      wait_irq();
      t0 = t_irq;
      chk("irq pair", 32'h3, {dsp_irq, mcu_irq});
      clr2();
      wait_irq();
      chk("byte period", 8 * BC, t_irq - t0);
      apb(0, 1'b0, 8'h00, 32'h0);
      d = rdat;
      chk("byte value", 32'h1, is_rot(rows[k].pat, rdat[7:0]));
      chk("dsp read irqs", 32'h1, {dsp_irq, mcu_irq});
      apb(1, 1'b0, 8'h00, 32'h0);
      chk("mcu data", d, rdat);
      chk("mcu read irq", 32'h0, mcu_irq);
      apb(1 - rows[k].p, 1'b1, 8'h04, 32'h0);
      apb(rows[k].p, 1'b0, 8'h04, 32'h0);
      chk("ctrl off", 32'h0, rdat);
      $display("row %0d done", k);
    end
    // clear bits act on their own port only
    apb(1, 1'b1, 8'h04, 32'h19);
    wait_irq();
    apb(0, 1'b1, 8'h08, 32'h1);
    chk("dsp clear bit", 32'h1, {dsp_irq, mcu_irq});
    apb(1, 1'b0, 8'h08, 32'h0);
    chk("mcu stat irq", 32'h1, rdat[0]);
    chk("synced flag", 32'h1, rdat[1]);
    apb(1, 1'b1, 8'h08, 32'h1);
    chk("mcu clear bit", 32'h0, {dsp_irq, mcu_irq});
    apb(1, 1'b0, 8'h0c, 32'h0);
    chk("unmapped err", 32'h1, rerr);
    chk("unmapped data", 32'h0, rdat);
    apb(0, 1'b0, 8'h0c, 32'h0);
    chk("dsp unmapped err", 32'h1, rerr);
    $display("clear and unmapped test done");
    // disabled: no bytes, no interrupts, last byte kept
    // both ports read the data register in the same cycles
    fork
      apb(0, 1'b0, 8'h00, 32'h0);
      apb(1, 1'b0, 8'h00, 32'h0);
    join
    d = prdata[0];
    chk("shared data", d, prdata[1]);
    apb(1, 1'b1, 8'h04, 32'h0);
    hit = 1'b0;
    repeat (24 * BC) begin
      @(posedge clock);
      #1;
      if (dsp_irq !== 1'b0 || mcu_irq !== 1'b0) hit = 1'b1;
    end
    chk("idle irqs", 32'h0, hit);
    apb(0, 1'b0, 8'h00, 32'h0);
    chk("kept data", d, rdat);
    chk("mapped err", 32'h0, rerr);
    $display("disable test done");
    // reset in mid-run returns every register to its idle value
    apb(0, 1'b1, 8'h04, 32'h19);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    chk("mid reset irqs", 32'h0, {dsp_irq, mcu_irq});
    apb(0, 1'b0, 8'h00, 32'h0);
    chk("mid reset data", 32'h0, rdat);
    apb(1, 1'b0, 8'h04, 32'h0);
    chk("mid reset ctrl", 32'h0, rdat);
    $display("mid-run reset test done");
    final_report();
  end
endmodule // tb
